// ==== hdl/iob_pkg.sv ====
// Package for the internal oscillator block: register map, fields, codes and timing
package iob_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] IOB_OFF_TUNING = 8'h00;
   localparam logic [7:0] IOB_OFF_CONTROL = 8'h04;
   localparam logic [7:0] IOB_OFF_CONFIG = 8'h08;
   localparam logic [7:0] IOB_OFF_STATUS = 8'h0C;
   // Tuning register fields and reset
   localparam int IOB_TUN_SRC_BIT = 7;
   localparam int IOB_TUN_MULT_BIT = 6;
   localparam int IOB_TUN_TRIM_MSB = 4;
   localparam logic [7:0] IOB_TUN_RESET = 8'h00;
   localparam logic [7:0] IOB_TUN_WMASK = 8'hDF;
   // Control register: frequency select in bits 6:4, reset to 1 MHz code
   localparam int IOB_CTL_FSEL_LSB = 4;
   localparam logic [2:0] IOB_FSEL_RESET = 3'h4;
   localparam logic [2:0] IOB_FSEL_8M = 3'h7;
   localparam logic [2:0] IOB_FSEL_4M = 3'h6;
   localparam logic [2:0] IOB_FSEL_31K = 3'h0;
   // Config register: primary config bits 3:0, features bits 7:4, clock select bit 8
   localparam int IOB_CFG_FEAT_LSB = 4;
   localparam int IOB_CFG_SEL_BIT = 8;
   localparam logic [3:0] IOB_PCFG_CLKOUT = 4'h9;
   localparam logic [3:0] IOB_PCFG_DUALIO = 4'h8;
   localparam logic [3:0] IOB_PCFG_RESET = 4'h8;
   // Settling time after a trim write
   localparam int IOB_SETTLE_US = 1000;
   localparam int IOB_CLK_MHZ = 125;
   localparam int IOB_SETTLE_CYC = IOB_SETTLE_US * IOB_CLK_MHZ;
   // Clock path selection
   typedef enum logic [1:0]
   {
      IOB_PATH_FAST = 2'b00,
      IOB_PATH_POST = 2'b01,
      IOB_PATH_SLOW = 2'b10
   } iob_path_t;
   // Oscillator control outputs travel together
   typedef struct packed
   {
      logic fast_en;
      logic slow_en;
      logic mult_on;
      iob_path_t path;
      logic [2:0] post_shift;
      logic [4:0] trim_applied;
   } iob_osc_ctl_t;
endpackage

// ==== hdl/iob_top.sv ====
// Internal oscillator block: registers, source enables, postscaler select, trim slew, pins
//
// Functional notes
// - Fast source 8 MHz direct or postscaled
// - Fast source on for 125k-8M selections
// - Slow RC on when selected or features
// - Frequency select picks direct, slow, postscaler
// - Clock-out mode drives clock/4 on pin
// - Dual I/O mode frees both pins
// - Slow RC unaffected by trim field
// - Trim slews, settles within 1 ms, status bit 8 flags done
// - Bit 7 picks 31 kHz source
// - Bit 6 enables 4x multiplier
// - Multiplier only under config and select
// - Multiplier controlled by software only
// - Zero trim gives calibrated 8 MHz
// - Select decode 111 8M, halving, 000 31k
// - Source bit picks fast/256 or slow RC
// - Reset frequency select is 1 MHz
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module iob_top
   import iob_pkg::*;
#(
   parameter int SETTLE_CYC = IOB_SETTLE_CYC, // Cycles for one full trim settle
   parameter int TRIM_W = 5 // Width of trim field
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dev_clk_div4, // Device clock divided by four
   input wire logic port_a_bit6_out, // Port data for second pin
   input wire logic port_a_bit6_oe,
   input wire logic port_a_bit7_out, // Port data for first pin
   input wire logic port_a_bit7_oe,
   input wire logic first_osc_pin_in,
   input wire logic second_osc_pin_in,
   output logic first_osc_pin_out,
   output logic first_osc_pin_oe,
   output logic second_osc_pin_out,
   output logic second_osc_pin_oe,
   output logic port_a_bit6_in,
   output logic port_a_bit7_in,
   output iob_osc_ctl_t osc_ctl // Controls to the analog oscillators
);
   // Elaboration check: trim field is fixed at five bits in the map
   if (TRIM_W != 5 || SETTLE_CYC < 1)
   begin : g_bad_param
      $error("iob_top: unsupported parameter values");
   end

   localparam int STEP_CYC_I = (SETTLE_CYC / 32 < 1) ? 1 : SETTLE_CYC / 32;
   localparam logic [31:0] STEP_CYC = 32'(STEP_CYC_I);

   logic low_freq_source_select; // Tuning bit 7
   logic multiplier_enable; // Tuning bit 6
   logic [4:0] trim_field; // Requested trim
   logic [4:0] trim_applied; // Slewing trim actually used
   logic [2:0] internal_freq_select; // Control register field
   logic [3:0] primary_osc_config; // Configuration code
   logic [3:0] feature_en; // Power-up timer, monitor, watchdog, two-speed
   logic internal_selected; // Internal block drives device clock
   logic [31:0] step_cnt; // Slew step timer
   logic mult_allowed;
   logic wr_ok;
   logic [31:0] rd_word;

   // Address decode used only for the slave error response
   function automatic logic is_mapped(input logic [7:0] a);
      return a == IOB_OFF_TUNING || a == IOB_OFF_CONTROL ||
             a == IOB_OFF_CONFIG || a == IOB_OFF_STATUS;
   endfunction

   // Zero wait state slave: access phase completes at once
   assign pready = 1'b1;
   assign wr_ok = psel && penable && pwrite;
   // Unmapped addresses answer with an error and no effect
   assign pslverr = psel && penable && !is_mapped(paddr);

   // Multiplier allowed only in internal pin modes at 4 or 8 MHz
   // multiplier gate conditions
   assign mult_allowed = (primary_osc_config == IOB_PCFG_CLKOUT ||
                          primary_osc_config == IOB_PCFG_DUALIO) &&
                         (internal_freq_select == IOB_FSEL_8M ||
                          internal_freq_select == IOB_FSEL_4M);

   // Tuning register writes; bit 5 is not stored
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_freq_source_select <= IOB_TUN_RESET[IOB_TUN_SRC_BIT];
         trim_field <= IOB_TUN_RESET[IOB_TUN_TRIM_MSB:0];
      end
      else if (wr_ok && paddr == IOB_OFF_TUNING)
      begin
         low_freq_source_select <= pwdata[IOB_TUN_SRC_BIT];
         trim_field <= pwdata[IOB_TUN_TRIM_MSB:0];
      end
   end

   // Multiplier enable: software only, writes ignored when not allowed
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         multiplier_enable <= IOB_TUN_RESET[IOB_TUN_MULT_BIT];
      else if (!mult_allowed)
         multiplier_enable <= 1'b0;
      else if (wr_ok && paddr == IOB_OFF_TUNING)
         multiplier_enable <= pwdata[IOB_TUN_MULT_BIT];
   end

   // Frequency select; reset lands on 1 MHz
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         internal_freq_select <= IOB_FSEL_RESET;
      else if (wr_ok && paddr == IOB_OFF_CONTROL)
         internal_freq_select <= pwdata[IOB_CTL_FSEL_LSB +: 3];
   end

   // Configuration stands in for fuses, writable so a bench can reach every mode
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         primary_osc_config <= IOB_PCFG_RESET;
         feature_en <= 4'h0;
         internal_selected <= 1'b1;
      end
      else if (wr_ok && paddr == IOB_OFF_CONFIG)
      begin
         primary_osc_config <= pwdata[3:0];
         feature_en <= pwdata[IOB_CFG_FEAT_LSB +: 4];
         internal_selected <= pwdata[IOB_CFG_SEL_BIT];
      end
   end

   // Trim slews one code per step so the frequency drifts rather than jumps;
   // 31 steps cover the whole range inside the settle time. Status bit 8 flags done.
   // gradual settle within 1 ms
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trim_applied <= 5'h00;
         step_cnt <= 32'h0000_0000;
      end
      else if (trim_applied == trim_field)
         step_cnt <= 32'h0000_0000;
      else if (step_cnt >= STEP_CYC - 32'h0000_0001)
      begin
         step_cnt <= 32'h0000_0000;
         if ($signed(trim_field) > $signed(trim_applied))
            trim_applied <= trim_applied + 5'h01;
         else
            trim_applied <= trim_applied - 5'h01;
      end
      else
         step_cnt <= step_cnt + 32'h0000_0001;
   end

   // Oscillator control outputs
   always_comb
   begin
      osc_ctl = '0;
      case (internal_freq_select)
         IOB_FSEL_8M:
         begin
            osc_ctl.path = IOB_PATH_FAST;
            osc_ctl.post_shift = 3'h0;
         end
         IOB_FSEL_31K:
         begin
            osc_ctl.path = low_freq_source_select ? IOB_PATH_POST : IOB_PATH_SLOW;
            osc_ctl.post_shift = 3'h0;
         end
         default:
         begin
            // Codes 6..1 divide 8 MHz by 2..64
            osc_ctl.path = IOB_PATH_POST;
            osc_ctl.post_shift = 3'h7 - internal_freq_select;
         end
      endcase
      osc_ctl.fast_en = internal_freq_select != IOB_FSEL_31K || low_freq_source_select;
      osc_ctl.slow_en = (internal_selected && osc_ctl.path == IOB_PATH_SLOW) ||
                        (|feature_en);
      osc_ctl.mult_on = multiplier_enable && mult_allowed;
      osc_ctl.trim_applied = trim_applied;
   end

   // Pin muxing for the internal oscillator pin modes
   always_comb
   begin
      // Other modes leave the pins to the oscillator circuitry
      first_osc_pin_out = 1'b0;
      first_osc_pin_oe = 1'b0;
      second_osc_pin_out = 1'b0;
      second_osc_pin_oe = 1'b0;
      port_a_bit6_in = 1'b0;
      port_a_bit7_in = 1'b0;
      if (primary_osc_config == IOB_PCFG_CLKOUT || primary_osc_config == IOB_PCFG_DUALIO)
      begin
         // first pin is port bit 7
         first_osc_pin_out = port_a_bit7_out;
         first_osc_pin_oe = port_a_bit7_oe;
         port_a_bit7_in = first_osc_pin_in;
      end
      if (primary_osc_config == IOB_PCFG_CLKOUT)
      begin
         second_osc_pin_out = dev_clk_div4;
         second_osc_pin_oe = 1'b1;
      end
      else if (primary_osc_config == IOB_PCFG_DUALIO)
      begin
         // second pin is port bit 6
         second_osc_pin_out = port_a_bit6_out;
         second_osc_pin_oe = port_a_bit6_oe;
         port_a_bit6_in = second_osc_pin_in;
      end
   end

   // Read mux
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (paddr)
         IOB_OFF_TUNING: rd_word = {24'h00_0000, low_freq_source_select,
                                    multiplier_enable, 1'b0, trim_field};
         IOB_OFF_CONTROL: rd_word = {25'h000_0000, internal_freq_select, 4'h0};
         IOB_OFF_CONFIG: rd_word = {23'h00_0000, internal_selected, feature_en,
                                    primary_osc_config};
         IOB_OFF_STATUS: rd_word = {23'h00_0000, trim_applied == trim_field,
                                    osc_ctl.post_shift, osc_ctl.fast_en,
                                    osc_ctl.slow_en, osc_ctl.mult_on, osc_ctl.path};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Read data registered at the end of the setup phase, held through access
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_word;
   end
endmodule // iob_top

// ==== tb/iob_checker.sv ====
// Port assertions for the internal oscillator block
`timescale 1ns/1ps
module iob_checker
   import iob_pkg::*;
#(
   parameter int SETTLE_CYC = 64 // Cycles for a full trim settle
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic dev_clk_div4,
   input wire logic port_a_bit6_out,
   input wire logic first_osc_pin_in,
   input wire logic port_a_bit7_in,
   input wire logic second_osc_pin_out,
   input wire logic second_osc_pin_oe,
   input iob_osc_ctl_t osc_ctl
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [4:0] tgt; // Last trim written
   int age; // Cycles since that write, saturating
   wire twr = psel && penable && pwrite && paddr == IOB_OFF_TUNING;
   wire fok = osc_ctl.path == IOB_PATH_FAST;
   wire pok = fok || (osc_ctl.path == IOB_PATH_POST && osc_ctl.post_shift == 3'h1);
   // Remember the target so the settle bound can be judged
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tgt <= '0;
         age <= SETTLE_CYC + 4;
      end
      else if (twr)
      begin
         tgt <= pwdata[4:0];
         age <= 0;
      end
      else if (age < SETTLE_CYC + 4)
         age <= age + 1;
   end
   property p_fast_en;
      osc_ctl.fast_en == (osc_ctl.path != IOB_PATH_SLOW);
   endproperty
   a_fast_en: assert property (p_fast_en) else $error("fast enable wrong");
   property p_slow_en;
      osc_ctl.path == IOB_PATH_SLOW |-> osc_ctl.slow_en;
   endproperty
   a_slow_en: assert property (p_slow_en) else $error("slow enable missing");
   property p_mult_drop;
      osc_ctl.mult_on && !pok |=> !osc_ctl.mult_on;
   endproperty
   a_mult_drop: assert property (p_mult_drop) else $error("multiplier kept");
   property p_mult_set;
      $rose(osc_ctl.mult_on) |-> $past(twr && pwdata[6]);
   endproperty
   a_mult_set: assert property (p_mult_set) else $error("multiplier self set");
   property p_pin_out;
      second_osc_pin_out != port_a_bit6_out |-> second_osc_pin_oe
         && second_osc_pin_out == dev_clk_div4;
   endproperty
   a_pin_out: assert property (p_pin_out) else $error("clock out pin wrong");
   property p_pin_in;
      port_a_bit7_in == first_osc_pin_in;
   endproperty
   a_pin_in: assert property (p_pin_in) else $error("first pin not port");
   property p_trim_step;
      $changed(osc_ctl.trim_applied) |-> 5'(osc_ctl.trim_applied
         - $past(osc_ctl.trim_applied)) inside {5'h01, 5'h1F} ##1 $stable(osc_ctl.trim_applied);
   endproperty
   a_trim_step: assert property (p_trim_step) else $error("trim jump");
   property p_trim_done;
      age >= SETTLE_CYC + 4 |-> osc_ctl.trim_applied == tgt;
   endproperty
   a_trim_done: assert property (p_trim_done) else $error("trim not settled");
   property p_reset_val;
      $rose(rst_n) |-> osc_ctl.path == IOB_PATH_POST && osc_ctl.post_shift == 3'h3;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("reset select wrong");
   cover property (osc_ctl.mult_on);
   cover property (osc_ctl.path == IOB_PATH_SLOW);
   cover property ($changed(osc_ctl.trim_applied));
endmodule // iob_checker

// ==== tb/iob_top_tb_top.sv ====
// Testbench for the internal oscillator block
`timescale 1ns/1ps
module iob_top_tb_top
   import iob_pkg::*;
;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, dev_clk_div4 = 0, first_osc_pin_in = 0, second_osc_pin_in = 0;
   logic port_a_bit6_out = 0, port_a_bit6_oe = 0, port_a_bit7_out = 0, port_a_bit7_oe = 0;
   logic first_osc_pin_out, first_osc_pin_oe, second_osc_pin_out, second_osc_pin_oe;
   logic port_a_bit6_in, port_a_bit7_in;
   iob_osc_ctl_t osc_ctl;
   int n_fail = 0, n_checks = 0, cyc = 0;
   // 125 MHz clock
   always #4 core_clk = ~core_clk;
   // Short settle so a full trim walk fits in 64 cycles
   iob_top #(.SETTLE_CYC(64)) i_iob_top (.core_clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .dev_clk_div4, .port_a_bit6_out,
      .port_a_bit6_oe, .port_a_bit7_out, .port_a_bit7_oe, .first_osc_pin_in,
      .second_osc_pin_in, .first_osc_pin_out, .first_osc_pin_oe, .second_osc_pin_out,
      .second_osc_pin_oe, .port_a_bit6_in, .port_a_bit7_in, .osc_ctl);
   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard, far above the run length
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, s, e);
      end
   endtask
   // One APB transfer; request held until pready is seen
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      @(negedge core_clk);
   endtask
   task automatic t_reset();
      apb(IOB_OFF_TUNING, 0, 0);
      chk(rd, 32'h0000_0000);
      chk(32'(osc_ctl.trim_applied), 32'h0000_0000);
      apb(IOB_OFF_CONTROL, 0, 0);
      chk(32'(rd[6:4]), 32'h0000_0004);
      apb(IOB_OFF_CONFIG, 0, 0);
      chk(rd, 32'h0000_0108);
      apb(IOB_OFF_STATUS, 0, 0);
      chk(rd, 32'h0000_0171);
   endtask
   task automatic t_decode();
      for (int f = 1; f < 8; f++)
      begin
         apb(IOB_OFF_CONTROL, 1, 32'(f) << 4);
         chk(32'(osc_ctl.path), 32'((f == 7) ? IOB_PATH_FAST : IOB_PATH_POST));
         if (f < 7)
            chk(32'(osc_ctl.post_shift), 32'(7 - f));
         chk(32'({osc_ctl.fast_en, osc_ctl.slow_en}), 32'h0000_0002);
      end
      apb(IOB_OFF_TUNING, 1, 32'h0000_0080);
      apb(IOB_OFF_CONTROL, 1, 32'h0000_0000);
      chk(32'({osc_ctl.fast_en, osc_ctl.slow_en, osc_ctl.path}), 32'h0000_0009);
      chk(32'(osc_ctl.post_shift), 32'h0000_0000);
      apb(IOB_OFF_TUNING, 1, 32'h0000_0000);
      chk(32'({osc_ctl.fast_en, osc_ctl.slow_en, osc_ctl.path}), 32'h0000_0006);
      apb(IOB_OFF_CONTROL, 1, 32'h0000_0040);
      apb(IOB_OFF_CONFIG, 1, 32'h0000_0118);
      chk(32'(osc_ctl.slow_en), 32'h0000_0001);
      apb(IOB_OFF_CONFIG, 1, 32'h0000_0108);
      chk(32'(osc_ctl.slow_en), 32'h0000_0000);
   endtask
   task automatic t_mult();
      apb(IOB_OFF_CONTROL, 1, 32'h0000_0070);
      apb(IOB_OFF_TUNING, 1, 32'h0000_0040);
      chk(32'(osc_ctl.mult_on), 32'h0000_0001);
      apb(IOB_OFF_CONTROL, 1, 32'h0000_0050);
      repeat (2) @(negedge core_clk);
      chk(32'(osc_ctl.mult_on), 32'h0000_0000);
      apb(IOB_OFF_TUNING, 0, 0);
      chk(rd, 32'h0000_0000);
      apb(IOB_OFF_TUNING, 1, 32'h0000_0040);
      apb(IOB_OFF_TUNING, 0, 0);
      chk(rd, 32'h0000_0000);
      apb(IOB_OFF_CONTROL, 1, 32'h0000_0060);
      apb(IOB_OFF_CONFIG, 1, 32'h0000_0109);
      apb(IOB_OFF_TUNING, 1, 32'h0000_0040);
      chk(32'(osc_ctl.mult_on), 32'h0000_0001);
      apb(IOB_OFF_TUNING, 1, 32'h0000_0000);
   endtask
   // Trim walks to each target; worst case is 0F to 10
   task automatic t_trim();
      logic [4:0] tv[3] = '{5'h1F, 5'h0F, 5'h10};
      apb(IOB_OFF_TUNING, 1, 32'h0000_003F);
      apb(IOB_OFF_TUNING, 0, 0);
      chk(rd, 32'h0000_001F);
      foreach (tv[i])
      begin
         apb(IOB_OFF_TUNING, 1, 32'(tv[i]));
         repeat (70) if (osc_ctl.trim_applied !== tv[i]) @(negedge core_clk);
         chk(32'(osc_ctl.trim_applied), 32'(tv[i]));
      end
      apb(IOB_OFF_TUNING, 1, 32'(tv[2]) + 32'h0000_0001);
      apb(IOB_OFF_TUNING, 0, 0);
      chk(rd, 32'h0000_0011);
      apb(IOB_OFF_TUNING, 1, rd - 32'h0000_0001);
      apb(IOB_OFF_TUNING, 0, 0);
      chk(rd, 32'h0000_0010);
   endtask
   task automatic t_pins();
      @(posedge core_clk);
      {dev_clk_div4, first_osc_pin_in, second_osc_pin_in} <= 3'b111;
      @(negedge core_clk);
      chk(32'({second_osc_pin_oe, second_osc_pin_out, port_a_bit7_in, port_a_bit6_in}),
         32'h0000_000E);
      apb(IOB_OFF_CONFIG, 1, 32'h0000_0108);
      @(posedge core_clk);
      {port_a_bit6_out, port_a_bit6_oe, port_a_bit7_out, port_a_bit7_oe} <= 4'hF;
      @(negedge core_clk);
      chk(32'({second_osc_pin_oe, second_osc_pin_out, first_osc_pin_oe, first_osc_pin_out,
         port_a_bit6_in, port_a_bit7_in}), 32'h0000_003F);
   endtask
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1;
      t_reset();
      t_decode();
      t_mult();
      t_trim();
      t_pins();
      apb(8'h10, 0, 0);
      chk({rd[30:0], er}, 32'h0000_0001);
      give_verdict();
   end
endmodule // iob_top_tb_top
bind iob_top iob_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk (.core_clk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .dev_clk_div4, .port_a_bit6_out, .first_osc_pin_in,
   .port_a_bit7_in, .second_osc_pin_out, .second_osc_pin_oe, .osc_ctl);
